// ### design/dmx_map.vh
// Constants for the data-move instruction decode and execute block
// Behaviour
// [RQ1] With a=0 and extended set on, file addresses up to 5Fh use indexed literal offset.
// [RQ2] Byte move from file: d=0 writes working register, d=1 writes file back.
// [RQ3] a=0 selects access bank; a=1 uses bank select register for the bank.
// [RQ4] File-to-file move is two words: prefix 1100 source, prefix 1111 destination.
// [RQ5] File-to-file move copies source byte to destination anywhere in 000h to FFFh.
// [RQ6] File-to-file move accepts the mapped working register as source or destination.
// [RQ7] Software never names pc low byte or stack top bytes as move destination.
// [RQ8] File-to-file: cycle one reads source in Q2; cycle two writes destination in Q4.
// [RQ9] Opcode 0000 0001 kkkk kkkk loads bank select register in one cycle.
// [RQ10] Bank select load forces bits 7:4 to zero.
// [RQ11] Opcode 0000 1110 kkkk kkkk loads the working register.
// [RQ12] Single-cycle moves: decode Q1, read Q2, process Q3, write Q4; flags only for byte move.
`ifndef DMX_MAP_VH
`define DMX_MAP_VH
// ****************************************
// Opcode fields, address constants and masks
// ****************************************
`define DMX_OP_MOVE_FILE_BYTE      6'h14
`define DMX_OP_FF1       4'hc
`define DMX_OP_FF2       4'hf
`define DMX_OP_LB        8'h01
`define DMX_OP_LW        8'h0e
`define DMX_ILO_MAX      8'h5f
`define DMX_ACC_SPLIT    8'h60
`define DMX_ACC_HI_BANK  4'hf
`define DMX_WREG_ADDR    12'hfe8
`define DMX_BSR_MASK     8'h0f
// ****************************************
// Quarter phases
// ****************************************
`define DMX_Q1           2'h0
`define DMX_Q2           2'h1
`define DMX_Q3           2'h2
`define DMX_Q4           2'h3
`endif

// ### design/dmx_qphase.v
// Quarter-phase sequencer for the instruction cycle
module dmx_qphase
(
   clk,
   srst,
   phase,
   last_q
);
`include "dmx_map.vh"
   input  wire       clk;
   input  wire       srst;
   output wire [1:0] phase;
   output wire       last_q;

   reg [1:0] ph_q;

   // Steps Q1 to Q4 and wraps
   always @(posedge clk)
   begin
      if (srst)
         ph_q <= `DMX_Q1;
      else
         ph_q <= ph_q + 2'h1;
   end

   assign phase  = ph_q;
   assign last_q = (ph_q == `DMX_Q4);
endmodule // dmx_qphase

// ### design/dmx_exec.v
// Decode and execute of the core data-move instructions
module dmx_exec
(
   REF_CLK,
   SRST,
   EXT_SET_EN,
   INSTR_WORD,
   RD_DATA,
   ILO_BASE,
   FETCH_REQ,
   PHASE,
   RD_EN,
   RD_ADDR,
   WR_EN,
   WR_ADDR,
   WR_DATA,
   FLAG_N,
   FLAG_Z,
   FLAG_WE,
   WREG,
   BANK_SEL,
   ILLEGAL_DEST
);
`include "dmx_map.vh"
   // ****************************************
   // Ports
   // ****************************************
   // Clock, reset and operand inputs
   input  wire        REF_CLK;
   input  wire        SRST;
   input  wire        EXT_SET_EN;
   input  wire [15:0] INSTR_WORD;
   input  wire [7:0]  RD_DATA;
   input  wire [11:0] ILO_BASE;
   // Memory strobes, flags and core registers
   output reg         FETCH_REQ;
   output reg  [1:0]  PHASE;
   output reg         RD_EN;
   output reg  [11:0] RD_ADDR;
   output reg         WR_EN;
   output reg  [11:0] WR_ADDR;
   output reg  [7:0]  WR_DATA;
   output reg         FLAG_N;
   output reg         FLAG_Z;
   output reg         FLAG_WE;
   output reg  [7:0]  WREG;
   output reg  [7:0]  BANK_SEL;
   output reg         ILLEGAL_DEST;

   // ****************************************
   // Internal state
   // ****************************************
   // Waiting for a copy destination word or not
   localparam ST_IDLE = 2'h0;
   localparam ST_FF2  = 2'h1;

   // Quarter phase, latched word and datapath holding
   wire [1:0]  ph;
   wire        last_q;
   reg  [15:0] ir_q;
   reg  [1:0]  st_q;
   reg  [1:0]  st_d;
   reg  [7:0]  data_q;
   reg  [11:0] src_q;
   reg  [11:0] eff_addr;
   reg  [1:0]  kind;

   // Instruction classes decoded from a first word
   localparam K_NONE = 2'h0;
   localparam K_MOVE_FILE_BYTE = 2'h1;
   localparam K_LIT  = 2'h2;
   localparam K_FF1  = 2'h3;

   // Quarter counter, restarts at Q1 with reset
   dmx_qphase u_qphase
   (
      .clk    (REF_CLK),
      .srst   (SRST),
      .phase  (ph),
      .last_q (last_q)
   );

   // ****************************************
   // Decode
   // ****************************************
   // Instruction class and effective file address
   always @*
   begin
      kind = K_NONE;
      if (st_q == ST_IDLE)
      begin
         if (ir_q[15:10] == `DMX_OP_MOVE_FILE_BYTE)
            kind = K_MOVE_FILE_BYTE;
         else if (ir_q[15:12] == `DMX_OP_FF1)                      // [RQ4]
            kind = K_FF1;
         else if (ir_q[15:8] == `DMX_OP_LB || ir_q[15:8] == `DMX_OP_LW) // [RQ9] [RQ11]
            kind = K_LIT;
      end
      if (!ir_q[8] && EXT_SET_EN && ir_q[7:0] <= `DMX_ILO_MAX)   // [RQ1]
         eff_addr = ILO_BASE + {4'h0, ir_q[7:0]};
      else if (ir_q[8])                                           // [RQ3]
         eff_addr = {BANK_SEL[3:0], ir_q[7:0]};
      else if (ir_q[7:0] < `DMX_ACC_SPLIT)
         eff_addr = {4'h0, ir_q[7:0]};
      else
         eff_addr = {`DMX_ACC_HI_BANK, ir_q[7:0]};
   end

   // Second word expected after the source word
   always @*
   begin
      case (st_q)
         ST_IDLE: st_d = (last_q && kind == K_FF1) ? ST_FF2 : ST_IDLE;
         ST_FF2:  st_d = last_q ? ST_IDLE : ST_FF2;
         default: st_d = ST_IDLE;
      endcase
   end

   // ****************************************
   // Execute
   // ****************************************
   // Per-quarter activity
   always @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         // Whole block back to idle, fetch restarts at Q1
         ir_q <= 16'h0000;
         st_q <= ST_IDLE;
         data_q <= 8'h00;
         src_q <= 12'h000;
         FETCH_REQ <= 1'b0;
         PHASE <= `DMX_Q1;
         RD_EN <= 1'b0;
         RD_ADDR <= 12'h000;
         WR_EN <= 1'b0;
         WR_ADDR <= 12'h000;
         WR_DATA <= 8'h00;
         FLAG_N <= 1'b0;
         FLAG_Z <= 1'b0;
         FLAG_WE <= 1'b0;
         WREG <= 8'h00;
         BANK_SEL <= 8'h00;
         ILLEGAL_DEST <= 1'b0;
      end
      else
      begin
         // Strobes default low so each one lasts a single clock
         st_q <= st_d;
         PHASE <= ph;
         RD_EN <= 1'b0;
         WR_EN <= 1'b0;
         FLAG_WE <= 1'b0;
         FETCH_REQ <= (ph == `DMX_Q4);
         // Q1: latch instruction word and decode
         if (ph == `DMX_Q1)                                       // [RQ12]
         begin
            ir_q <= INSTR_WORD;
            ILLEGAL_DEST <= 1'b0;
         end
         // Q2: operand read
         if (ph == `DMX_Q2)
         begin
            if (kind == K_MOVE_FILE_BYTE)
            begin
               RD_EN <= 1'b1;
               RD_ADDR <= eff_addr;
            end
            else if (kind == K_FF1)                                // [RQ8] [RQ5]
            begin
               RD_EN <= 1'b1;
               RD_ADDR <= ir_q[11:0];
               src_q <= ir_q[11:0];
            end
         end
         // Q3: capture read data or literal
         if (ph == `DMX_Q3)
         begin
            if (kind == K_MOVE_FILE_BYTE || kind == K_FF1)
               data_q <= RD_DATA;
            else if (kind == K_LIT)
               data_q <= ir_q[7:0];
         end
         // Q4: write target
         if (ph == `DMX_Q4)
         begin
            if (kind == K_MOVE_FILE_BYTE)
            begin
               FLAG_WE <= 1'b1;                                    // [RQ12]
               FLAG_N <= data_q[7];
               FLAG_Z <= (data_q == 8'h00);
               if (ir_q[9])                                        // [RQ2]
               begin
                  WR_EN <= 1'b1;
                  WR_ADDR <= eff_addr;
                  WR_DATA <= data_q;
               end
               else
                  WREG <= data_q;
            end
            else if (kind == K_LIT && ir_q[15:8] == `DMX_OP_LB)
               BANK_SEL <= data_q & `DMX_BSR_MASK;                 // [RQ10]
            else if (kind == K_LIT)
               WREG <= data_q;                                     // [RQ11]
            else if (st_q == ST_FF2 && ir_q[15:12] == `DMX_OP_FF2)  // [RQ8]
            begin
               // Mapped working register kept coherent either way
               if (ir_q[11:0] == `DMX_WREG_ADDR)                   // [RQ6]
                  WREG <= data_q;
               else
               begin
                  WR_EN <= 1'b1;
                  WR_ADDR <= ir_q[11:0];
                  WR_DATA <= (src_q == `DMX_WREG_ADDR) ? WREG : data_q;
               end
            end
            // Second word lacks the destination prefix
            else if (st_q == ST_FF2)
               ILLEGAL_DEST <= 1'b1;                               // Bad second word
         end
      end
   end
endmodule // dmx_exec

// ### dv/dmx_mem_model.sv
// Program and data memory model on the far side of the data-move block
module dmx_mem_model
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        rd_en,
   input  wire logic [11:0] rd_addr,
   output logic      [15:0] instr_word,
   output logic      [7:0]  rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] prog [16];
   logic [5:0]  cnt_q;
   // Empty program and idle lines at time zero
   initial
   begin
      prog = '{default: 16'h0};
      instr_word = 16'h0;
      rd_data = 8'h0;
   end
   // Clock count since reset picks the word, one per four clocks
   always @(posedge clk)
      cnt_q <= srst ? 6'h0 : cnt_q + 6'h1;
   // Word held whole cycle; read data only after a strobe, else scrambled
   always @(negedge clk)
   begin
      instr_word <= prog[cnt_q[5:2]];
      rd_data    <= rd_en ? (rd_addr[7:0] ^ {2{rd_addr[11:8]}}) : ~rd_data;
   end
endmodule // dmx_mem_model

// ### dv/dmx_exec_checker.sv
// Port-level assertions for the data-move decode and execute block
module dmx_exec_checker
(
   input wire logic        REF_CLK,
   input wire logic        SRST,
   input wire logic [15:0] INSTR_WORD,
   input wire logic [7:0]  RD_DATA,
   input wire logic        RD_EN,
   input wire logic [11:0] RD_ADDR,
   input wire logic        WR_EN,
   input wire logic [11:0] WR_ADDR,
   input wire logic [7:0]  WR_DATA,
   input wire logic        FLAG_WE,
   input wire logic [7:0]  WREG,
   input wire logic [7:0]  BANK_SEL
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   // ****************************************
   // Timing and decode checks
   // ****************************************
   property p_rd_gap; RD_EN |=> !RD_EN [*3]; endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("read strobe too close");
   property p_bank_hi; BANK_SEL[7:4] == 4'h0; endproperty
   a_bank_hi: assert property (p_bank_hi) else $error("bank high bits set");
   property p_bank_lb; $changed(BANK_SEL) |-> $past(INSTR_WORD[15:8], 3) == 8'h01
      && $past(INSTR_WORD[3:0], 3) == BANK_SEL[3:0]; endproperty
   a_bank_lb: assert property (p_bank_lb) else $error("bank load wrong");
   property p_wreg_lw; $changed(WREG) && $past(INSTR_WORD[15:8], 3) == 8'h0e
      |-> WREG == $past(INSTR_WORD[7:0], 3); endproperty
   a_wreg_lw: assert property (p_wreg_lw) else $error("working load wrong");
   property p_flag_we; FLAG_WE |-> $past(INSTR_WORD[15:10], 3) == 6'h14; endproperty
   a_flag_we: assert property (p_flag_we) else $error("flags on wrong op");
   property p_ff_src; RD_EN && $past(INSTR_WORD[15:12]) == 4'hc |-> RD_ADDR == $past(INSTR_WORD[11:0]); endproperty
   a_ff_src: assert property (p_ff_src) else $error("copy source wrong");
   property p_ff_dst; WR_EN && $past(INSTR_WORD[15:12], 3) == 4'hf
      |-> WR_ADDR == $past(INSTR_WORD[11:0], 3); endproperty
   a_ff_dst: assert property (p_ff_dst) else $error("copy target wrong");
   property p_move_file_byte_d; WR_EN && $past(INSTR_WORD[15:9], 3) == 7'h29 |-> WR_DATA == $past(RD_DATA, 2); endproperty
   a_move_file_byte_d: assert property (p_move_file_byte_d) else $error("file write-back wrong");
endmodule // dmx_exec_checker
bind dmx_exec dmx_exec_checker u_chk (.*);

// ### dv/tb_top.sv
// Self-checking bench for the data-move decode and execute block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        REF_CLK, SRST, EXT_SET_EN, FETCH_REQ, RD_EN, WR_EN;
   logic        FLAG_N, FLAG_Z, FLAG_WE, ILLEGAL_DEST;
   logic [1:0]  PHASE;
   logic [15:0] INSTR_WORD;
   logic [11:0] ILO_BASE, RD_ADDR, WR_ADDR;
   logic [7:0]  RD_DATA, WR_DATA, WREG, BANK_SEL;
   logic [11:0] ra [$], wa [$], wd [$];
   int          failures, checks, bad;
   dmx_exec u_dut
   (
      .REF_CLK      (REF_CLK),
      .SRST         (SRST),
      .EXT_SET_EN   (EXT_SET_EN),
      .INSTR_WORD   (INSTR_WORD),
      .RD_DATA      (RD_DATA),
      .ILO_BASE     (ILO_BASE),
      .FETCH_REQ    (FETCH_REQ),
      .PHASE        (PHASE),
      .RD_EN        (RD_EN),
      .RD_ADDR      (RD_ADDR),
      .WR_EN        (WR_EN),
      .WR_ADDR      (WR_ADDR),
      .WR_DATA      (WR_DATA),
      .FLAG_N       (FLAG_N),
      .FLAG_Z       (FLAG_Z),
      .FLAG_WE      (FLAG_WE),
      .WREG         (WREG),
      .BANK_SEL     (BANK_SEL),
      .ILLEGAL_DEST (ILLEGAL_DEST)
   );
   dmx_mem_model u_pm
   (
      .clk        (REF_CLK),
      .srst       (SRST),
      .rd_en      (RD_EN),
      .rd_addr    (RD_ADDR),
      .instr_word (INSTR_WORD),
      .rd_data    (RD_DATA)
   );
   // 200 MHz clock
   initial
   begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end
   // Record read and write strobes where they are settled
   always @(negedge REF_CLK)
   begin
      if (RD_EN === 1'b1) ra.push_back(RD_ADDR);
      if (WR_EN === 1'b1) wa.push_back(WR_ADDR);
      if (WR_EN === 1'b1) wd.push_back({4'h0, WR_DATA});
      if (ILLEGAL_DEST === 1'b1) bad++;
   end
   // Data the memory model returns for an address
   function automatic logic [11:0] dv(input logic [11:0] a);
      return {4'h0, a[7:0] ^ {2{a[11:8]}}};
   endfunction
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Reset, run n words, then clear the program
   task automatic run(input int n);
      SRST = 1'b1;
      repeat (5) @(negedge REF_CLK);
      ra = {};
      wa = {};
      wd = {};
      bad = 0;
      SRST = 1'b0;
      repeat (4 * n + 4) @(negedge REF_CLK);
      u_pm.prog = '{default: 16'h0};
   endtask
   task automatic t_lit;
      EXT_SET_EN = 1'b0;
      u_pm.prog[0] = 16'h5210;
      u_pm.prog[1] = 16'h0ea5;
      u_pm.prog[2] = 16'h01fb;
      run(3);
      chk(ra[0], 12'h010);
      chk(wa[0], 12'h010);
      chk(wd[0], dv(12'h010));
      chk({4'h0, WREG}, 12'h0a5);
      chk({4'h0, BANK_SEL}, 12'h00b);
      chk({9'h0, FETCH_REQ, PHASE}, 12'h007);
   endtask
   // Copy whose second word lacks the destination prefix
   task automatic t_bad;
      u_pm.prog[0] = 16'hc123;
      u_pm.prog[1] = 16'h0ea5;
      run(2);
      chk(12'(bad), 12'h001);
      chk(12'(wa.size()), 12'h000);
   endtask
   // Destinations avoid the pc low and stack top bytes
   task automatic t_ff;
      u_pm.prog[0] = 16'hc123;
      u_pm.prog[1] = 16'hffe8;
      u_pm.prog[2] = 16'hcfe8;
      u_pm.prog[3] = 16'hf200;
      u_pm.prog[4] = 16'hc456;
      u_pm.prog[5] = 16'hf345;
      run(6);
      chk({4'h0, WREG}, dv(12'h123));
      chk(wa[$-1], 12'h200);
      chk(wd[$-1], dv(12'h123));
      chk(wa[$], 12'h345);
      chk(wd[$], dv(12'h456));
   endtask
   task automatic t_move_file_byte;
      EXT_SET_EN = 1'b1;
      u_pm.prog[0] = 16'h0103;
      u_pm.prog[1] = 16'h5320;
      u_pm.prog[2] = 16'h5070;
      u_pm.prog[3] = 16'h5010;
      run(4);
      chk(ra[$-2], 12'h320);
      chk(ra[$-1], 12'hf70);
      chk(ra[$], 12'h490);
      chk(wd[$], dv(12'h320));
      chk({4'h0, WREG}, dv(12'h490));
      chk({10'h0, FLAG_N, FLAG_Z}, 12'h002);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      SRST = 1'b1;
      EXT_SET_EN = 1'b0;
      ILO_BASE = 12'h480;
      failures = 0;
      checks = 0;
      bad = 0;
      @(negedge REF_CLK);
      t_lit();
      t_ff();
      t_move_file_byte();
      t_bad();
      finish_test();
   end
endmodule // tb_top
